// *** hw/acs_top.sv ***
// Channel scan, range selection and result coding for a SAR converter.
// Assumes AXI4-Lite on aclk; the serial host and front end on link_clk.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Manual mode converts the channel last written by software.
// - Auto mode advances to the next channel on each chip-select fall.
// - Auto mode visits only enabled channels, in ascending order; with none enabled it steps through every channel.
// - Each channel keeps its own range, applied when it is converted.
// - A range sent on the data input holds for one scan only.
// - A control bit enables the internal reference; off powers it down.
// - After reset the external reference is selected.
// - A control bit enables the temperature sensor; off after reset.
// - Selecting the sensor overrides channel and range, routes it in.
// - Auto scan resumes where it stopped once the sensor is deselected.
// - Results leave as 16-bit words, channel then 12-bit code, most significant bit first.
// - Bipolar ranges use offset binary, zero at 800h, saturating.
// - Unipolar ranges use straight binary, saturating at FFFh.
module acs_top (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Serial link
    input wire logic link_clk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout,
    // Analog front end
    input wire logic signed [13:0] sample_in,
    output logic [3:0] mux_sel,
    output logic [2:0] range_sel,
    output logic ref_int_en,
    output logic temp_pwr_en
);
    import acs_pkg::*;

    typedef struct packed {
        acs_ast_e st;
        logic aw_got;
        logic w_got;
        logic [7:0] waddr;
        logic [31:0] wword;
        logic [3:0] wbe;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic auto;
        logic [2:0] mch;
        logic tsel;
        logic [7:0] scan;
        logic [23:0] rng;
        logic ref_en;
        logic temp_en;
        logic req;
        logic ak1;
        logic ak2;
        logic r1;
        logic r2;
        logic r3;
        logic [15:0] res;
        logic res_new;
    } acs_a_s;

    typedef struct packed {
        acs_lst_e st;
        logic cs_q;
        logic [3:0] cnt;
        logic [3:0] mux_sel;
        logic [2:0] range_sel;
        logic bip;
        logic dout;
        logic [11:0] code;
        logic [2:0] ptr;
        logic ovr_pend;
        logic [2:0] ovr_rng;
        logic [3:0] dcap;
        logic q1;
        logic q2;
        logic ack;
        logic auto;
        logic [2:0] mch;
        logic tsel;
        logic [7:0] scan;
        logic [23:0] rng;
        logic [15:0] res;
        logic rtgl;
    } acs_l_s;

    acs_a_s a;
    acs_a_s next_a;
    acs_l_s l;
    acs_l_s next_l;
    logic rs1;
    logic rs2;

    function automatic logic [31:0] acs_merge(input logic [31:0] old, input logic [31:0] d,
                                              input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [2:0] acs_first(input logic [7:0] m, input logic [2:0] s);
        logic [2:0] c;
        logic [2:0] idx;
        logic hit;
        c = s;
        hit = 1'b0;
        for (int i = 0; i < ACS_NCH; i++) begin
            idx = s + 3'(i);
            if (m[idx] && !hit) begin
                c = idx;
                hit = 1'b1;
            end
        end
        return c;
    endfunction

    function automatic logic [11:0] acs_code(input logic signed [13:0] s, input logic bip);
        logic signed [14:0] v;
        v = bip ? ($signed({{2{s[13]}}, s[13:1]}) + ACS_BIP_ZERO) : $signed({s[13], s});
        if (v < 0) begin
            return 12'h000;
        end else if (v > ACS_CODE_MAX) begin
            return 12'hfff;
        end
        return v[11:0];
    endfunction

    // ****************************************
    // Register side
    // ****************************************
    always_comb begin
        logic [31:0] w;
        w = 32'h0;
        next_a = a;
        next_a.ak1 = l.ack;
        next_a.ak2 = a.ak1;
        next_a.r1 = l.rtgl;
        next_a.r2 = a.r1;
        next_a.r3 = a.r2;
        if (awvalid && a.awready) begin
            next_a.aw_got = 1'b1;
            next_a.waddr = awaddr;
        end
        if (wvalid && a.wready) begin
            next_a.w_got = 1'b1;
            next_a.wword = wdata;
            next_a.wbe = wstrb;
        end
        case (a.st)
            ACS_IDLE: begin
                if (a.aw_got && a.w_got) begin
                    next_a.aw_got = 1'b0;
                    next_a.w_got = 1'b0;
                    next_a.bresp = ACS_RESP_OK;
                    next_a.st = ACS_RESP;
                    next_a.bvalid = 1'b1;
                    if (a.waddr == ACS_A_CTRL) begin
                        w = acs_merge({27'h0, a.tsel, a.mch, a.auto}, a.wword, a.wbe);
                        next_a.auto = w[ACS_CTRL_AUTO];
                        next_a.mch = w[ACS_CTRL_MCH +: 3];
                        next_a.tsel = w[ACS_CTRL_TSEL];
                    end else if (a.waddr == ACS_A_AUX) begin
                        w = acs_merge({30'h0, a.temp_en, a.ref_en}, a.wword, a.wbe);
                        next_a.ref_en = w[ACS_AUX_REF];
                        next_a.temp_en = w[ACS_AUX_TEMP];
                    end else if (a.waddr == ACS_A_SCAN) begin
                        w = acs_merge({24'h0, a.scan}, a.wword, a.wbe);
                        next_a.scan = w[7:0];
                    end else if (a.waddr == ACS_A_RANGE) begin
                        w = acs_merge({8'h0, a.rng}, a.wword, a.wbe);
                        next_a.rng = w[23:0];
                    end else if (a.waddr != ACS_A_RESULT) begin
                        next_a.bresp = ACS_RESP_ERR;
                    end
                    // Settings the link uses wait for its handshake
                    if (a.waddr == ACS_A_CTRL || a.waddr == ACS_A_SCAN ||
                        a.waddr == ACS_A_RANGE) begin
                        next_a.req = ~a.req;
                        next_a.bvalid = 1'b0;
                        next_a.st = ACS_SYNC;
                    end
                end
            end
            ACS_SYNC: begin
                if (a.ak2 == a.req) begin
                    next_a.bvalid = 1'b1;
                    next_a.st = ACS_RESP;
                end
            end
            ACS_RESP: begin
                if (bready) begin
                    next_a.bvalid = 1'b0;
                    next_a.st = ACS_IDLE;
                end
            end
            default: begin
                next_a.st = ACS_IDLE;
            end
        endcase
        if (a.rvalid && rready) begin
            next_a.rvalid = 1'b0;
        end
        if (arvalid && a.arready) begin
            next_a.rvalid = 1'b1;
            next_a.rresp = ACS_RESP_OK;
            next_a.rdata = 32'h0;
            if (araddr == ACS_A_CTRL) begin
                next_a.rdata = {27'h0, a.tsel, a.mch, a.auto};
            end else if (araddr == ACS_A_AUX) begin
                next_a.rdata = {30'h0, a.temp_en, a.ref_en};
            end else if (araddr == ACS_A_SCAN) begin
                next_a.rdata = {24'h0, a.scan};
            end else if (araddr == ACS_A_RANGE) begin
                next_a.rdata = {8'h0, a.rng};
            end else if (araddr == ACS_A_RESULT) begin
                next_a.rdata = {15'h0, a.res_new, a.res};
                next_a.res_new = 1'b0;
            end else begin
                next_a.rresp = ACS_RESP_ERR;
            end
        end
        // New result beats a clear in the same cycle
        if (a.r2 != a.r3) begin
            next_a.res = l.res;
            next_a.res_new = 1'b1;
        end
        next_a.awready = next_a.st == ACS_IDLE && !next_a.aw_got;
        next_a.wready = next_a.st == ACS_IDLE && !next_a.w_got;
        next_a.arready = !next_a.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            a <= '0;
            a.st <= ACS_IDLE;
            a.scan <= ACS_RST_SCAN;
            a.rng <= ACS_RST_RANGE;
            a.ref_en <= 1'b0;
            a.temp_en <= 1'b0;
        end else begin
            a <= next_a;
        end
    end

    // ****************************************
    // Link side
    // ****************************************
    // Reset reaches the link domain through two flops
    always_ff @(posedge link_clk) begin
        rs1 <= aresetn;
        rs2 <= rs1;
    end

    always_comb begin
        logic [2:0] c;
        logic [2:0] r;
        logic [15:0] word;
        c = 3'h0;
        r = 3'h0;
        word = 16'h0;
        next_l = l;
        next_l.q1 = a.req;
        next_l.q2 = l.q1;
        next_l.cs_q = cs_n;
        // Settings are stable while the toggle is unanswered
        if (l.q2 != l.ack) begin
            next_l.ack = l.q2;
            next_l.auto = a.auto;
            next_l.mch = a.mch;
            next_l.tsel = a.tsel;
            next_l.scan = a.scan;
            next_l.rng = a.rng;
        end
        case (l.st)
            ACS_L_IDLE: begin
                if (l.cs_q && !cs_n) begin
                    if (l.tsel) begin
                        next_l.mux_sel = ACS_TEMP_CH;
                        r = ACS_RNG_TEMP;
                    end else begin
                        if (l.auto) begin
                            c = acs_first(l.scan, l.ptr);
                            next_l.ptr = c + 3'h1;
                        end else begin
                            c = l.mch;
                        end
                        next_l.mux_sel = {1'b0, c};
                        r = l.ovr_pend ? l.ovr_rng : l.rng[3*c +: 3];
                    end
                    next_l.ovr_pend = 1'b0;
                    next_l.range_sel = r;
                    next_l.bip = !(r == ACS_RNG_U10 || r == ACS_RNG_U5);
                    next_l.cnt = 4'h0;
                    next_l.dcap = 4'h0;
                    next_l.dout = next_l.mux_sel[3];
                    next_l.st = ACS_L_SHIFT;
                end
            end
            ACS_L_SHIFT: begin
                if (cs_n) begin
                    // Aborted frame gives no result
                    next_l.dout = 1'b0;
                    next_l.st = ACS_L_IDLE;
                end else begin
                    next_l.cnt = l.cnt + 4'h1;
                    if (l.cnt <= ACS_HDR_LAST) begin
                        next_l.dcap = {l.dcap[2:0], din};
                    end
                    if (l.cnt == ACS_CODE_LOAD) begin
                        next_l.code = acs_code(sample_in, l.bip);
                    end
                    word = {l.mux_sel, next_l.code};
                    next_l.dout = word[4'hf - next_l.cnt];
                    if (l.cnt == ACS_FRAME_LAST) begin
                        next_l.dout = 1'b0;
                        next_l.res = {l.mux_sel, l.code};
                        next_l.rtgl = ~l.rtgl;
                        next_l.ovr_pend = l.dcap[3];
                        next_l.ovr_rng = l.dcap[2:0];
                        next_l.st = ACS_L_IDLE;
                    end
                end
            end
            default: begin
                next_l.st = ACS_L_IDLE;
            end
        endcase
    end

    always_ff @(posedge link_clk) begin
        if (!rs2) begin
            l <= '0;
            l.st <= ACS_L_IDLE;
            l.cs_q <= 1'b1;
            l.scan <= ACS_RST_SCAN;
            l.rng <= ACS_RST_RANGE;
        end else begin
            l <= next_l;
        end
    end

    assign awready = a.awready;
    assign wready = a.wready;
    assign bvalid = a.bvalid;
    assign bresp = a.bresp;
    assign arready = a.arready;
    assign rvalid = a.rvalid;
    assign rdata = a.rdata;
    assign rresp = a.rresp;
    assign ref_int_en = a.ref_en;
    assign temp_pwr_en = a.temp_en;
    assign dout = l.dout;
    assign mux_sel = l.mux_sel;
    assign range_sel = l.range_sel;

    // ****************************************
    // Checks
    // ****************************************
    a_ref_reset: assert property (@(posedge aclk) $rose(aresetn) |=> !ref_int_en)
        else $error("internal reference on after reset");
    a_temp_reset: assert property (@(posedge aclk) $rose(aresetn) |=> !temp_pwr_en)
        else $error("sensor powered after reset");
    a_ref_cause: assert property (@(posedge aclk) disable iff (!aresetn)
        $changed(ref_int_en) |-> $past(a.st == ACS_IDLE && a.aw_got && a.w_got &&
        a.waddr == ACS_A_AUX))
        else $error("reference enable changed without a write");
    a_manual_chan: assert property (@(posedge link_clk) disable iff (!rs2)
        $rose(l.st == ACS_L_SHIFT) && !$past(l.auto) && !$past(l.tsel) |->
        mux_sel == {1'b0, $past(l.mch)})
        else $error("manual channel not converted");
    a_auto_step: assert property (@(posedge link_clk) disable iff (!rs2)
        $rose(l.st == ACS_L_SHIFT) && $past(l.auto) && !$past(l.tsel) |->
        l.ptr == mux_sel[2:0] + 3'h1)
        else $error("auto pointer did not advance");
    a_auto_enabled: assert property (@(posedge link_clk) disable iff (!rs2)
        $rose(l.st == ACS_L_SHIFT) && $past(l.auto) && !$past(l.tsel) && |$past(l.scan)
        |-> l.scan[mux_sel[2:0]])
        else $error("disabled channel visited");
    a_range_apply: assert property (@(posedge link_clk) disable iff (!rs2)
        $rose(l.st == ACS_L_SHIFT) && !$past(l.tsel) && !$past(l.ovr_pend) |->
        range_sel == l.rng[3*mux_sel[2:0] +: 3])
        else $error("wrong range applied");
    a_override_once: assert property (@(posedge link_clk) disable iff (!rs2)
        $rose(l.st == ACS_L_SHIFT) |-> !l.ovr_pend)
        else $error("override outlived its scan");
    a_temp_route: assert property (@(posedge link_clk) disable iff (!rs2)
        $rose(l.st == ACS_L_SHIFT) && $past(l.tsel) |->
        mux_sel == ACS_TEMP_CH && range_sel == ACS_RNG_TEMP)
        else $error("sensor not routed");
    a_temp_hold: assert property (@(posedge link_clk) disable iff (!rs2)
        $rose(l.st == ACS_L_SHIFT) && $past(l.tsel) |-> $stable(l.ptr))
        else $error("scan pointer moved during sensor read");
    a_first_bit: assert property (@(posedge link_clk) disable iff (!rs2)
        l.st == ACS_L_SHIFT && l.cnt == 4'h3 && !cs_n |=> !cs_n |-> dout == l.code[11])
        else $error("code MSB not first");
    a_bip_zero: assert property (@(posedge link_clk) disable iff (!rs2)
        l.st == ACS_L_SHIFT && l.cnt == ACS_CODE_LOAD && !cs_n && l.bip &&
        sample_in == 14'sh0 |=> l.code == 12'h800)
        else $error("bipolar zero not 800h");
    a_uni_floor: assert property (@(posedge link_clk) disable iff (!rs2)
        l.st == ACS_L_SHIFT && l.cnt == ACS_CODE_LOAD && !cs_n && !l.bip &&
        sample_in < 0 |=> l.code == 12'h000)
        else $error("unipolar code below zero");
    c_auto_frame: cover property (@(posedge link_clk) disable iff (!rs2)
        $rose(l.st == ACS_L_SHIFT) && l.auto);
    c_temp_frame: cover property (@(posedge link_clk) disable iff (!rs2)
        $rose(l.st == ACS_L_SHIFT) && mux_sel == ACS_TEMP_CH);
    c_override: cover property (@(posedge link_clk) disable iff (!rs2)
        $rose(l.st == ACS_L_SHIFT) && $past(l.ovr_pend));
    c_result: cover property (@(posedge aclk) disable iff (!aresetn) $rose(a.res_new));
endmodule
`default_nettype wire

// *** hw/acs_pkg.sv ***
// Constants, field layouts and state codes for the channel scan block.
// Assumes an AXI4-Lite master on aclk and a serial host on link_clk.
package acs_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] ACS_A_CTRL = 8'h00;
    localparam logic [7:0] ACS_A_AUX = 8'h04;
    localparam logic [7:0] ACS_A_SCAN = 8'h08;
    localparam logic [7:0] ACS_A_RANGE = 8'h0c;
    localparam logic [7:0] ACS_A_RESULT = 8'h10;
    localparam int ACS_CTRL_AUTO = 0;
    localparam int ACS_CTRL_MCH = 1;
    localparam int ACS_CTRL_TSEL = 4;
    localparam int ACS_AUX_REF = 0;
    localparam int ACS_AUX_TEMP = 1;
    localparam int ACS_RES_CH = 12;
    localparam int ACS_RES_NEW = 16;
    localparam logic [7:0] ACS_RST_SCAN = 8'hff;
    localparam logic [23:0] ACS_RST_RANGE = 24'h000000;
    localparam logic [1:0] ACS_RESP_OK = 2'h0;
    localparam logic [1:0] ACS_RESP_ERR = 2'h2;
    // ****************************************
    // Channels, ranges and coding
    // ****************************************
    localparam int ACS_NCH = 8;
    localparam logic [3:0] ACS_TEMP_CH = 4'h8;
    localparam logic [2:0] ACS_RNG_B10 = 3'h0;
    localparam logic [2:0] ACS_RNG_B5 = 3'h1;
    localparam logic [2:0] ACS_RNG_B2 = 3'h2;
    localparam logic [2:0] ACS_RNG_U10 = 3'h3;
    localparam logic [2:0] ACS_RNG_U5 = 3'h4;
    localparam logic [2:0] ACS_RNG_TEMP = ACS_RNG_U10;
    localparam logic signed [14:0] ACS_BIP_ZERO = 15'sh0800;
    localparam logic signed [14:0] ACS_CODE_MAX = 15'sh0fff;
    localparam logic [3:0] ACS_CODE_LOAD = 4'h2;
    localparam logic [3:0] ACS_HDR_LAST = 4'h3;
    localparam logic [3:0] ACS_FRAME_LAST = 4'hf;
    // ****************************************
    // State codes
    // ****************************************
    typedef enum logic [2:0] {
        ACS_IDLE = 3'b001,
        ACS_SYNC = 3'b010,
        ACS_RESP = 3'b100
    } acs_ast_e;
    typedef enum logic [1:0] {
        ACS_L_IDLE = 2'b01,
        ACS_L_SHIFT = 2'b10
    } acs_lst_e;
endpackage

// *** verif/acs_link_host.sv ***
// Serial host and analog front end facing the channel scan block.
// Assumes link_clk runs free and the frame timing of acs_top.
`timescale 1ns/1ps
`default_nettype none
module acs_link_host (
    // Link
    input wire logic link_clk,
    output logic cs_n,
    output logic din,
    input wire logic dout,
    // Front end
    output logic signed [13:0] sample_in
);
    initial begin
        cs_n = 1'b1;
        din = 1'b0;
        sample_in = 14'sh0;
    end
    // Host sensor scaling
    // Offset and slope hold for a 2.5 V reference only
    localparam real TEMP_OFS = 3777.2;
    localparam real TEMP_SLOPE = 0.47;
    function automatic real deg_c(input logic [11:0] code);
        return (real'(code) - TEMP_OFS) / TEMP_SLOPE;
    endfunction
    // ****
    // One frame
    // ****
    // override bits, word
    task automatic frame(input logic [3:0] ctl, input logic signed [13:0] s,
            output logic [15:0] w);
        @(posedge link_clk);
        cs_n <= 1'b0;
        sample_in <= s;
        @(posedge link_clk);
        for (int k = 0; k < 16; k++) begin
            // Unused din bits toggle, never a stale level
            din <= (k < 4) ? ctl[3 - k] : ~din;
            @(negedge link_clk);
            w[15 - k] = dout;
            @(posedge link_clk);
        end
        cs_n <= 1'b1;
        sample_in <= ~s;
        @(posedge link_clk);
    endtask
endmodule
`default_nettype wire

// *** verif/test_adc_channel_scan_and_coding.sv ***
// Bench for acs_top: register bus tasks plus serial frames.
// Assumes acs_pkg and the host model acs_link_host.
`timescale 1ns/1ps
`default_nettype none
module test_adc_channel_scan_and_coding;
    import acs_pkg::*;
    logic aclk, aresetn, link_clk, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, dout, cs_n, din;
    logic ref_int_en, temp_pwr_en;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, q;
    logic [3:0] wstrb, mux_sel;
    logic [1:0] bresp, rresp, r;
    logic [2:0] range_sel;
    logic signed [13:0] sample_in;
    logic [15:0] w;
    int err_total, comparisons, cyc;
    logic [2:0] trng [10] = '{0, 1, 2, 0, 1, 3, 4, 3, 4, 3};
    logic signed [13:0] tsmp [10] = '{0, 2, -2, 8190, -8192, 0, 1, 4095, 5000, -5};
    logic [11:0] texp [10] = '{'h800, 'h801, 'h7ff, 'hfff, 0, 0, 1, 'hfff, 'hfff, 0};
    logic [3:0] tch [6] = '{2, 5, 7, 2, 8, 5};
    acs_top uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready, .link_clk, .cs_n, .din, .dout,
        .sample_in, .mux_sel, .range_sel, .ref_int_en, .temp_pwr_en);
    acs_link_host host (.link_clk, .cs_n, .din, .dout, .sample_in);
    always #2.5 aclk = ~aclk;
    // Odd start offset keeps the two clocks apart in phase
    initial begin
        link_clk = 1'b0;
        #1.3;
        forever #15 link_clk = ~link_clk;
    end
    // ****
    // Tasks
    // ****
    task automatic close_out();
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb, tr, td;
        @(posedge aclk);
        if (we) begin
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
        end else begin
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
        end
        // Sample mid cycle, act on the following edge
        do begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bready && bvalid;
            tr = arvalid && arready;
            td = rready && rvalid;
            if (tb) r = bresp;
            if (td) q = rdata;
            if (td) r = rresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
            if (tr) arvalid <= 1'b0;
            if (td) rready <= 1'b0;
        end while (awvalid || wvalid || bready || arvalid || rready);
    endtask
    // Hang guard, runs need a few thousand cycles
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 30000) begin
            err_total++;
            close_out();
        end
    end
    // ****
    // Sequence
    // ****
    initial begin
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, q, r} = '0;
        wstrb = 4'hf;
        {err_total, comparisons, cyc} = '0;
        // Link side needs four of its own edges in reset too
        repeat (6) @(posedge aclk);
        repeat (4) @(posedge link_clk);
        @(posedge aclk);
        aresetn <= 1'b1;
        repeat (30) @(posedge aclk);
        chk(32'(ref_int_en), 0);
        chk(32'(temp_pwr_en), 0);
        bus(0, ACS_A_SCAN, 0);
        chk(q, 32'hff);
        bus(0, ACS_A_RANGE, 0);
        chk(q, 0);
        bus(1, ACS_A_AUX, 32'h3);
        chk(32'({ref_int_en, temp_pwr_en, r}), 32'hc);
        bus(1, ACS_A_AUX, 0);
        chk(32'({ref_int_en, temp_pwr_en}), 0);
        bus(0, 8'h14, 0);
        chk(q, 0);
        chk(32'(r), 32'(ACS_RESP_ERR));
        bus(1, ACS_A_CTRL, 32'ha);
        for (int i = 0; i < 10; i++) begin
            bus(1, ACS_A_RANGE, 32'(trng[i]) << 15);
            host.frame(4'h0, tsmp[i], w);
            chk(32'(w), {20'h5, texp[i]});
            chk(32'(range_sel), 32'(trng[i]));
            bus(0, ACS_A_RESULT, 0);
            chk(q, {15'h0, 1'b1, 4'h5, texp[i]});
        end
        bus(0, ACS_A_RESULT, 0);
        chk(q, 32'h5000);
        host.frame(4'h9, 14'sh0, w);
        chk(32'(w), 32'h5000);
        host.frame(4'h0, 14'sh0, w);
        chk(32'({range_sel, w}), 32'h15800);
        host.frame(4'h0, 14'sh0, w);
        chk(32'(w), 32'h5000);
        bus(1, ACS_A_RANGE, 0);
        bus(1, ACS_A_SCAN, 32'ha4);
        bus(1, ACS_A_CTRL, 32'h1);
        for (int i = 0; i < 6; i++) begin
            if (i == 3) bus(1, ACS_A_AUX, 32'h2);
            if (i == 4) bus(1, ACS_A_CTRL, 32'h11);
            if (i == 5) bus(1, ACS_A_CTRL, 32'h1);
            host.frame(4'h0, 14'sh0, w);
            chk(32'(w), {16'h0, tch[i], tch[i] == 8 ? 12'h0 : 12'h800});
            chk(32'({mux_sel, range_sel}), {tch[i], tch[i] == 8 ? 3'h3 : 3'h0});
        end
        chk(32'(int'(host.deg_c(12'heca))), 32'd19);
        close_out();
    end
endmodule
`default_nettype wire
